// *** vcr_pkg.sv ***
// Shared constants for the voice codec control register bank
package vcr_pkg;

  // Register indices reached through the serial pointer byte
  localparam logic [7:0] VCR_IDX_MODE_ONE = 8'h00;
  localparam logic [7:0] VCR_IDX_MODE_TWO = 8'h01;
  localparam logic [7:0] VCR_IDX_GAIN = 8'h02;
  localparam logic [7:0] VCR_IDX_SIDETONE = 8'h03;
  localparam logic [7:0] VCR_IDX_TONE = 8'h04;
  localparam int VCR_NUM_REGS = 5;

  // Initial values loaded by the power-down pin
  localparam logic [7:0] VCR_INIT_MODE_ONE = 8'h00;
  localparam logic [7:0] VCR_INIT_MODE_TWO = 8'h00;
  localparam logic [7:0] VCR_INIT_GAIN = 8'h33;
  localparam logic [7:0] VCR_INIT_SIDETONE = 8'h00;
  localparam logic [7:0] VCR_INIT_TONE = 8'h00;
  localparam logic [7:0] VCR_UNMAPPED_READ = 8'h00;

  // Basic mode one fields
  localparam int VCR_B_A_LAW = 7;
  localparam int VCR_B_SPK_PON = 6;
  localparam int VCR_B_ALL_DOWN = 5;
  localparam int VCR_B_TX_DOWN = 4;
  localparam int VCR_B_RX_DOWN = 3;
  localparam int VCR_B_SLOPE_EN = 2;
  localparam int VCR_B_SLOPE_SEL = 1;
  localparam int VCR_B_LINEAR = 0;

  // Basic mode two fields
  localparam int VCR_F_MIC_HI = 7;
  localparam int VCR_F_MIC_LO = 6;
  localparam int VCR_F_OUT_HI = 5;
  localparam int VCR_F_OUT_LO = 4;
  localparam int VCR_B_SHORT_FRAME = 3;
  localparam int VCR_B_SWITCH = 1;
  localparam int VCR_B_RX_PAD = 0;
  localparam logic [1:0] VCR_AMP_NONE = 2'h3;

  // Gain register fields
  localparam int VCR_B_TX_OFF = 7;
  localparam int VCR_F_TX_GAIN_HI = 6;
  localparam int VCR_F_TX_GAIN_LO = 4;
  localparam int VCR_B_RX_OFF = 3;
  localparam int VCR_F_RX_GAIN_HI = 2;
  localparam int VCR_F_RX_GAIN_LO = 0;

  // Side tone register fields
  localparam int VCR_F_SIDE_HI = 7;
  localparam int VCR_F_SIDE_LO = 5;
  localparam int VCR_B_TONE_ON = 4;
  localparam int VCR_F_RTONE_HI = 3;
  localparam int VCR_F_RTONE_LO = 0;

  // Tone mode register fields
  localparam int VCR_B_DTMF = 7;
  localparam int VCR_B_TONE_SEND = 6;
  localparam int VCR_F_FREQ_HI = 4;
  localparam int VCR_F_LOWGRP_HI = 3;
  localparam int VCR_F_LOWGRP_LO = 2;
  localparam int VCR_F_HIGRP_HI = 1;
  localparam int VCR_F_HIGRP_LO = 0;

  // Gain laws in dB: base at the lowest active code plus step per code
  localparam logic signed [7:0] VCR_TX_GAIN_BASE_DB = -8'sd6;
  localparam logic signed [7:0] VCR_TX_GAIN_STEP_DB = 8'sd2;
  localparam logic signed [7:0] VCR_RX_GAIN_BASE_DB = -8'sd12;
  localparam logic signed [7:0] VCR_RX_GAIN_STEP_DB = 8'sd3;
  localparam logic signed [7:0] VCR_SIDE_BASE_DB = -8'sd15;
  localparam logic signed [7:0] VCR_RTONE_BASE_DB = -8'sd34;
  localparam logic signed [7:0] VCR_TONE_STEP_DB = 8'sd2;
  localparam logic signed [7:0] VCR_TONE_LOW_BASE_DBM0 = -8'sd16;
  localparam logic signed [7:0] VCR_TONE_HIGH_BASE_DBM0 = -8'sd14;

  // DTMF group frequencies in Hz
  localparam logic [11:0] VCR_LOW_HZ [4] = '{12'd697, 12'd770, 12'd852, 12'd941};
  localparam logic [11:0] VCR_HIGH_HZ [4] = '{12'd1209, 12'd1336, 12'd1477, 12'd1633};

  // Serial slave address, arbitrary value
  localparam logic [6:0] VCR_SLAVE_ADDR = 7'h2a;
  localparam logic [3:0] VCR_BITS_PER_BYTE = 4'h8;

  // Serial engine states
  typedef enum logic [3:0] {
    VCR_ST_IDLE,
    VCR_ST_ADDR,
    VCR_ST_ACK_ADDR,
    VCR_ST_PTR,
    VCR_ST_ACK_PTR,
    VCR_ST_WDATA,
    VCR_ST_ACK_WDATA,
    VCR_ST_RDATA,
    VCR_ST_RACK
  } vcr_state_t;

endpackage

// *** vcr_codec_ctrl.sv ***
// How it works
// - Mode one bit 7 picks A-law over mu-law
// - Mode one bit 6 powers speaker amplifiers
// - Bit 5 or pin powers down; bit 5 keeps registers
// - Power-down pin loads every initial value
// - Bits 4 and 3 power down each path
// - Bit 2 enables slope filter, bit 1 response
// - Bit 0 selects 14-bit linear PCM
// - Mode two bits 7:6 pick microphone amplifier
// - Mode two bits 5:4 pick output amplifier
// - Mode two bit 3 selects short frame sync
// - Mode two bit 1 routes analog switch
// - Gain bits 7 and 3 mute PCM
// - Transmit gain -6 to +8 dB steps 2
// - Receive gain -12 to +9 dB steps 3
// - Tone level is base plus transmit gain
// - Side tone gain off or -15 to -3
// - Side tone bit 4 switches tone generator
// - Receive tone gain off or -34 to -6
// - Tone bit 7 DTMF, bit 6 tone send
// - DTMF ignores top bit, picks two groups
`timescale 1ns/1ps
`default_nettype none

module vcr_codec_ctrl (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clock_en,
  input wire logic i_power_down_pin_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_a_law_select,
  output logic o_linear_code_select,
  output logic o_speaker_amp_power_on,
  output logic o_global_power_down,
  output logic o_transmit_power_down,
  output logic o_receive_power_down,
  output logic o_slope_filter_enable,
  output logic o_slope_response_select,
  output logic [2:0] o_input_amp_enable,
  output logic [2:0] o_output_amp_enable,
  output logic o_short_frame_select,
  output logic o_switch_to_a,
  output logic o_switch_to_c,
  output logic o_receive_pad_enable,
  output logic o_transmit_pcm_off,
  output logic o_receive_pcm_off,
  output logic signed [7:0] o_transmit_gain_db,
  output logic signed [7:0] o_receive_gain_db,
  output logic o_sidetone_enable,
  output logic signed [7:0] o_sidetone_gain_db,
  output logic o_tone_generator_on,
  output logic o_receive_tone_enable,
  output logic signed [7:0] o_receive_tone_gain_db,
  output logic o_dual_tone_select,
  output logic o_tone_send,
  output logic [11:0] o_low_tone_hz,
  output logic [11:0] o_high_tone_hz,
  output logic [4:0] o_other_tone_code,
  output logic signed [7:0] o_tone_low_level_dbm0,
  output logic signed [7:0] o_tone_high_level_dbm0
);
  import vcr_pkg::*;

  // Gain law: base plus step per code above first
  function automatic logic signed [7:0] gain_db(input logic [3:0] code,
                                                input logic [3:0] first,
                                                input logic signed [7:0] base,
                                                input logic signed [7:0] step);
    logic signed [7:0] delta;
    delta = $signed({4'h0, code}) - $signed({4'h0, first});
    gain_db = 8'(base + 8'(delta * step));
  endfunction

  // Selector to one-hot; all-ones selects none
  function automatic logic [2:0] amp_onehot(input logic [1:0] sel);
    amp_onehot = (sel == VCR_AMP_NONE) ? 3'h0 : 3'(3'h1 << sel);
  endfunction

  // Pin synchronisers, three stages each
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [2:0] pin_sync;
  logic scl_f; // Filtered clock level
  logic sda_f; // Filtered data level
  logic pin_f; // Filtered power-down pin, low means reset
  logic scl_d; // Previous filtered clock
  logic sda_d; // Previous filtered data

  // Synchroniser chains
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      pin_sync <= 3'h7;
    end else if (i_clock_en) begin
      scl_sync <= {scl_sync[1:0], i_scl};
      sda_sync <= {sda_sync[1:0], i_sda};
      pin_sync <= {pin_sync[1:0], i_power_down_pin_n};
    end
  end

  // Filtered levels: only the later two stages are compared
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      pin_f <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (i_clock_en) begin
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      if (pin_sync[1] == pin_sync[2]) begin
        pin_f <= pin_sync[2];
      end
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  // Bus events derived from filtered levels
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign bus_start = scl_f & scl_d & sda_d & ~sda_f;
  assign bus_stop = scl_f & scl_d & ~sda_d & sda_f;

  // Register storage
  logic [7:0] ctrl_reg [VCR_NUM_REGS];
  logic [7:0] init_val [VCR_NUM_REGS];
  assign init_val[0] = VCR_INIT_MODE_ONE;
  assign init_val[1] = VCR_INIT_MODE_TWO;
  assign init_val[2] = VCR_INIT_GAIN;
  assign init_val[3] = VCR_INIT_SIDETONE;
  assign init_val[4] = VCR_INIT_TONE;

  // Serial engine state
  vcr_state_t state;
  logic [7:0] shift; // Received or outgoing byte
  logic [3:0] bit_cnt; // Bits moved in the current byte
  logic [7:0] ptr; // Register pointer, auto-increments
  logic read_mode; // Direction bit of the address byte
  logic wr_en; // One-cycle write strobe to the register store
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_byte; // Byte at the pointer, zero when unmapped
  assign rd_byte = (ptr < 8'(VCR_NUM_REGS)) ? ctrl_reg[ptr[2:0]] : VCR_UNMAPPED_READ;

  // Serial slave engine
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= VCR_ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      ptr <= 8'h00;
      read_mode <= 1'b0;
      o_sda_oe <= 1'b0;
      wr_en <= 1'b0;
      wr_idx <= 8'h00;
      wr_data <= 8'h00;
    end else if (i_clock_en) begin
      wr_en <= 1'b0;
      if (!pin_f) begin
        // Device in pin reset: line released, engine idle
        state <= VCR_ST_IDLE;
        ptr <= 8'h00;
        o_sda_oe <= 1'b0;
      end else if (bus_start) begin
        // Start or repeated start
        state <= VCR_ST_ADDR;
        bit_cnt <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state <= VCR_ST_IDLE;
        o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        // Data is sampled while the clock is high
        unique case (state)
          VCR_ST_ADDR, VCR_ST_PTR, VCR_ST_WDATA: begin
            shift <= {shift[6:0], sda_f};
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end
          VCR_ST_RDATA: begin
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end
          VCR_ST_RACK: begin
            read_mode <= ~sda_f; // Master acknowledge keeps reading
          end
          VCR_ST_IDLE, VCR_ST_ACK_ADDR, VCR_ST_ACK_PTR, VCR_ST_ACK_WDATA: begin
          end
        endcase
      end else if (scl_fall) begin
        // Line is changed only while the clock is low
        unique case (state)
          VCR_ST_IDLE: begin
          end
          VCR_ST_ADDR: begin
            if (bit_cnt == VCR_BITS_PER_BYTE) begin
              if (shift[7:1] == VCR_SLAVE_ADDR) begin
                read_mode <= shift[0];
                o_sda_oe <= 1'b1;
                state <= VCR_ST_ACK_ADDR;
              end else begin
                state <= VCR_ST_IDLE; // Not ours, stay silent
              end
            end
          end
          VCR_ST_PTR: begin
            if (bit_cnt == VCR_BITS_PER_BYTE) begin
              ptr <= shift;
              o_sda_oe <= 1'b1;
              state <= VCR_ST_ACK_PTR;
            end
          end
          VCR_ST_WDATA: begin
            if (bit_cnt == VCR_BITS_PER_BYTE) begin
              // Value stored as written, unused bits included
              wr_en <= 1'b1;
              wr_idx <= ptr;
              wr_data <= shift;
              ptr <= 8'(ptr + 8'h01);
              o_sda_oe <= 1'b1;
              state <= VCR_ST_ACK_WDATA;
            end
          end
          VCR_ST_ACK_ADDR: begin
            bit_cnt <= 4'h0;
            if (read_mode) begin
              // First read bit goes out, most significant first
              o_sda_oe <= ~rd_byte[7];
              shift <= {rd_byte[6:0], 1'b0};
              ptr <= 8'(ptr + 8'h01);
              state <= VCR_ST_RDATA;
            end else begin
              o_sda_oe <= 1'b0;
              state <= VCR_ST_PTR;
            end
          end
          VCR_ST_ACK_PTR, VCR_ST_ACK_WDATA: begin
            bit_cnt <= 4'h0;
            o_sda_oe <= 1'b0;
            state <= VCR_ST_WDATA;
          end
          VCR_ST_RDATA: begin
            if (bit_cnt == VCR_BITS_PER_BYTE) begin
              o_sda_oe <= 1'b0; // Release for master acknowledge
              state <= VCR_ST_RACK;
            end else begin
              o_sda_oe <= ~shift[7];
              shift <= {shift[6:0], 1'b0};
            end
          end
          VCR_ST_RACK: begin
            bit_cnt <= 4'h0;
            if (read_mode) begin
              o_sda_oe <= ~rd_byte[7];
              shift <= {rd_byte[6:0], 1'b0};
              ptr <= 8'(ptr + 8'h01);
              state <= VCR_ST_RDATA;
            end else begin
              state <= VCR_ST_IDLE; // Not acknowledged ends the read
            end
          end
        endcase
      end
    end
  end

  // Open-drain data line only ever pulls low
  assign o_sda_out = 1'b0;

  // Register store: pin loads initial values, writes hold
  generate
    for (genvar g = 0; g < VCR_NUM_REGS; g++) begin : g_reg
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          ctrl_reg[g] <= (g == 2) ? VCR_INIT_GAIN : VCR_INIT_MODE_ONE;
        end else if (i_clock_en) begin
          if (!pin_f) begin
            ctrl_reg[g] <= init_val[g];
          end else if (wr_en && wr_idx == 8'(g)) begin
            ctrl_reg[g] <= wr_data;
          end
        end
      end
    end
  endgenerate

  // Field views
  logic [7:0] m1;
  logic [7:0] m2;
  logic [7:0] gn;
  logic [7:0] st;
  logic [7:0] tn;
  logic all_down;
  assign m1 = ctrl_reg[VCR_IDX_MODE_ONE[2:0]];
  assign m2 = ctrl_reg[VCR_IDX_MODE_TWO[2:0]];
  assign gn = ctrl_reg[VCR_IDX_GAIN[2:0]];
  assign st = ctrl_reg[VCR_IDX_SIDETONE[2:0]];
  assign tn = ctrl_reg[VCR_IDX_TONE[2:0]];
  // Software power-down ORed with the inverted pin, registers untouched
  assign all_down = m1[VCR_B_ALL_DOWN] | ~pin_f;

  // Decoded controls, registered one cycle after the store
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_a_law_select <= 1'b0;
      o_linear_code_select <= 1'b0;
      o_speaker_amp_power_on <= 1'b0;
      o_global_power_down <= 1'b0;
      o_transmit_power_down <= 1'b0;
      o_receive_power_down <= 1'b0;
      o_slope_filter_enable <= 1'b0;
      o_slope_response_select <= 1'b0;
      o_input_amp_enable <= 3'h0;
      o_output_amp_enable <= 3'h0;
      o_short_frame_select <= 1'b0;
      o_switch_to_a <= 1'b0;
      o_switch_to_c <= 1'b0;
      o_receive_pad_enable <= 1'b0;
    end else if (i_clock_en) begin
      o_a_law_select <= m1[VCR_B_A_LAW];
      o_linear_code_select <= m1[VCR_B_LINEAR];
      // Amplifiers also drop out when the whole device sleeps
      o_speaker_amp_power_on <= m1[VCR_B_SPK_PON] & ~all_down;
      o_global_power_down <= all_down;
      o_transmit_power_down <= m1[VCR_B_TX_DOWN] | all_down;
      o_receive_power_down <= m1[VCR_B_RX_DOWN] | all_down;
      o_slope_filter_enable <= m1[VCR_B_SLOPE_EN];
      o_slope_response_select <= m1[VCR_B_SLOPE_SEL];
      // Unselected amplifiers stay off, outputs floating
      o_input_amp_enable <= (all_down | m1[VCR_B_TX_DOWN]) ? 3'h0 :
                            amp_onehot(m2[VCR_F_MIC_HI:VCR_F_MIC_LO]);
      o_output_amp_enable <= (all_down | m1[VCR_B_RX_DOWN]) ? 3'h0 :
                             amp_onehot(m2[VCR_F_OUT_HI:VCR_F_OUT_LO]);
      o_short_frame_select <= m2[VCR_B_SHORT_FRAME];
      // Exactly one terminal joined to common; the other floats
      o_switch_to_a <= ~m2[VCR_B_SWITCH];
      o_switch_to_c <= m2[VCR_B_SWITCH];
      o_receive_pad_enable <= m2[VCR_B_RX_PAD];
    end
  end

  // Gain and tone controls
  logic signed [7:0] tx_gain;
  assign tx_gain = gain_db({1'b0, gn[VCR_F_TX_GAIN_HI:VCR_F_TX_GAIN_LO]}, 4'h0,
                           VCR_TX_GAIN_BASE_DB, VCR_TX_GAIN_STEP_DB);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_transmit_pcm_off <= 1'b0;
      o_receive_pcm_off <= 1'b0;
      o_transmit_gain_db <= 8'sh00;
      o_receive_gain_db <= 8'sh00;
      o_sidetone_enable <= 1'b0;
      o_sidetone_gain_db <= 8'sh00;
      o_tone_generator_on <= 1'b0;
      o_receive_tone_enable <= 1'b0;
      o_receive_tone_gain_db <= 8'sh00;
      o_dual_tone_select <= 1'b0;
      o_tone_send <= 1'b0;
      o_low_tone_hz <= 12'h000;
      o_high_tone_hz <= 12'h000;
      o_other_tone_code <= 5'h00;
      o_tone_low_level_dbm0 <= 8'sh00;
      o_tone_high_level_dbm0 <= 8'sh00;
    end else if (i_clock_en) begin
      o_transmit_pcm_off <= gn[VCR_B_TX_OFF];
      o_receive_pcm_off <= gn[VCR_B_RX_OFF];
      o_transmit_gain_db <= tx_gain;
      o_receive_gain_db <= gain_db({1'b0, gn[VCR_F_RX_GAIN_HI:VCR_F_RX_GAIN_LO]}, 4'h0,
                                   VCR_RX_GAIN_BASE_DB, VCR_RX_GAIN_STEP_DB);
      // Code zero switches the side tone path off
      o_sidetone_enable <= st[VCR_F_SIDE_HI:VCR_F_SIDE_LO] != 3'h0;
      o_sidetone_gain_db <= gain_db({1'b0, st[VCR_F_SIDE_HI:VCR_F_SIDE_LO]}, 4'h1,
                                    VCR_SIDE_BASE_DB, VCR_TONE_STEP_DB);
      o_tone_generator_on <= st[VCR_B_TONE_ON];
      // Code zero mutes the receive tone
      o_receive_tone_enable <= st[VCR_F_RTONE_HI:VCR_F_RTONE_LO] != 4'h0;
      o_receive_tone_gain_db <= gain_db(st[VCR_F_RTONE_HI:VCR_F_RTONE_LO], 4'h1,
                                        VCR_RTONE_BASE_DB, VCR_TONE_STEP_DB);
      o_dual_tone_select <= tn[VCR_B_DTMF];
      o_tone_send <= tn[VCR_B_TONE_SEND];
      // Top frequency bit plays no part in the DTMF pair
      o_low_tone_hz <= VCR_LOW_HZ[tn[VCR_F_LOWGRP_HI:VCR_F_LOWGRP_LO]];
      o_high_tone_hz <= VCR_HIGH_HZ[tn[VCR_F_HIGRP_HI:VCR_F_HIGRP_LO]];
      o_other_tone_code <= tn[VCR_F_FREQ_HI:0];
      // Transmitted tone levels follow the transmit gain
      o_tone_low_level_dbm0 <= 8'(VCR_TONE_LOW_BASE_DBM0 + tx_gain);
      o_tone_high_level_dbm0 <= 8'(VCR_TONE_HIGH_BASE_DBM0 + tx_gain);
    end
  end

endmodule

`default_nettype wire

// *** vcr_codec_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module vcr_codec_ctrl_sva (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_power_down_pin_n,
  input wire logic i_scl,
  input wire logic o_a_law_select,
  input wire logic o_speaker_amp_power_on,
  input wire logic o_global_power_down,
  input wire logic o_transmit_power_down,
  input wire logic o_receive_power_down,
  input wire logic [2:0] o_input_amp_enable,
  input wire logic o_switch_to_a,
  input wire logic o_switch_to_c,
  input wire logic signed [7:0] o_transmit_gain_db,
  input wire logic signed [7:0] o_receive_gain_db,
  input wire logic signed [7:0] o_tone_low_level_dbm0,
  input wire logic signed [7:0] o_tone_high_level_dbm0
);
  logic [1:0] up_cnt; // Edges since reset
  // Saturating age counter
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  property p_spk_gate;
    o_speaker_amp_power_on |-> !o_global_power_down;
  endproperty
  a_spk_gate: assert property (p_spk_gate) else $error("speaker on while powered down");
  property p_path_down;
    o_global_power_down |-> o_transmit_power_down && o_receive_power_down;
  endproperty
  a_path_down: assert property (p_path_down) else $error("path up in power down");
  property p_in_amp;
    $onehot0(o_input_amp_enable) && (!o_transmit_power_down || o_input_amp_enable == 3'h0);
  endproperty
  a_in_amp: assert property (p_in_amp) else $error("input amp select wrong");
  property p_switch;
    up_cnt == 2'h3 |-> o_switch_to_a != o_switch_to_c;
  endproperty
  a_switch: assert property (p_switch) else $error("switch routing wrong");
  property p_tone_lvl;
    up_cnt == 2'h3 |-> o_tone_low_level_dbm0 == o_transmit_gain_db - 8'sd16
      && o_tone_high_level_dbm0 == o_transmit_gain_db - 8'sd14;
  endproperty
  a_tone_lvl: assert property (p_tone_lvl) else $error("tone level wrong");
  property p_gain_set;
    o_transmit_gain_db inside {-6, -4, -2, 0, 2, 4, 6, 8}
      && o_receive_gain_db inside {-12, -9, -6, -3, 0, 3, 6, 9};
  endproperty
  a_gain_set: assert property (p_gain_set) else $error("gain off the table");
  property p_pin_down;
    $fell(i_power_down_pin_n) |-> ##[1:8] o_global_power_down;
  endproperty
  a_pin_down: assert property (p_pin_down) else $error("pin did not power down");
  property p_pin_init;
    !i_power_down_pin_n [*8] |=> o_transmit_gain_db == 8'sd0
      && o_receive_gain_db == -8'sd3 && !o_a_law_select;
  endproperty
  a_pin_init: assert property (p_pin_init) else $error("pin reset values wrong");
  property p_hold;
    (i_scl && i_power_down_pin_n && up_cnt == 2'h3) [*8]
      |-> $stable(o_transmit_gain_db) && $stable(o_a_law_select);
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved while bus idle");
  c_gpd: cover property ($rose(o_global_power_down));
  c_law: cover property ($rose(o_a_law_select));
  c_spk: cover property (o_speaker_amp_power_on);
endmodule
bind vcr_codec_ctrl vcr_codec_ctrl_sva i_sva (.*);
`default_nettype wire

// *** vcr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module vcr_host_model (
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_pull
);
  import vcr_pkg::*;
  localparam int HALF = 6; // Scl phase in clocks, longer than the filter needs
  // Bus idle
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // Data moves only while scl is low
  task automatic bit_io(input logic b, output logic s);
    tick(3);
    o_sda_pull <= ~b;
    tick(HALF);
    o_scl <= 1'b1;
    tick(HALF);
    s = i_sda;
    o_scl <= 1'b0;
  endtask
  // p low: start, p high: stop
  task automatic cond(input logic p);
    tick(3);
    o_sda_pull <= p;
    tick(HALF);
    o_scl <= 1'b1;
    tick(HALF);
    o_sda_pull <= ~p;
    tick(HALF);
    if (!p) o_scl <= 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ok = ok & ~s;
  endtask
  // Every read byte is refused
  task automatic get_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(1'b1, s);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] p, input logic [7:0] v,
                           output logic ok);
    if (p == VCR_IDX_MODE_TWO) v[2] = 1'b0;
    if (p == VCR_IDX_TONE) v[5] = 1'b0;
    ok = 1'b1;
    cond(1'b0);
    put_byte(a, ok);
    put_byte(p, ok);
    put_byte(v, ok);
    cond(1'b1);
  endtask
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
    logic ok;
    ok = 1'b1;
    cond(1'b0);
    put_byte({VCR_SLAVE_ADDR, 1'b0}, ok);
    put_byte(p, ok);
    cond(1'b0);
    put_byte({VCR_SLAVE_ADDR, 1'b1}, ok);
    get_byte(d);
    cond(1'b1);
  endtask
endmodule
`default_nettype wire

// *** vcr_codec_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %0d seen %0d", n, e, g); end end
module vcr_codec_ctrl_tb_top;
  import vcr_pkg::*;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic pin_n = 1'b1; // Power-down pin
  logic scl, pull, oe, law, lin, spk, gpd, txpd, rxpd, sfe, sfs, sfr, to_a, to_c, pad;
  logic txo, rxo, sten, tgon, rten, dual, send;
  logic [2:0] inamp, outamp;
  logic signed [7:0] txg, rxg, stg, rtg, tlo, thi;
  logic [11:0] lhz, hhz;
  logic [4:0] oth;
  int errors = 0;
  int cmp_count = 0;
  wire logic sda; // Open-drain line with pull-up
  assign sda = ~(pull | oe);
  vcr_codec_ctrl i_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_clock_en(1'b1),
    .i_power_down_pin_n(pin_n), .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(oe),
    .o_a_law_select(law), .o_linear_code_select(lin), .o_speaker_amp_power_on(spk),
    .o_global_power_down(gpd), .o_transmit_power_down(txpd), .o_receive_power_down(rxpd),
    .o_slope_filter_enable(sfe), .o_slope_response_select(sfs), .o_input_amp_enable(inamp),
    .o_output_amp_enable(outamp), .o_short_frame_select(sfr), .o_switch_to_a(to_a),
    .o_switch_to_c(to_c), .o_receive_pad_enable(pad), .o_transmit_pcm_off(txo),
    .o_receive_pcm_off(rxo), .o_transmit_gain_db(txg), .o_receive_gain_db(rxg),
    .o_sidetone_enable(sten), .o_sidetone_gain_db(stg), .o_tone_generator_on(tgon),
    .o_receive_tone_enable(rten), .o_receive_tone_gain_db(rtg), .o_dual_tone_select(dual),
    .o_tone_send(send), .o_low_tone_hz(lhz), .o_high_tone_hz(hhz), .o_other_tone_code(oth),
    .o_tone_low_level_dbm0(tlo), .o_tone_high_level_dbm0(thi));
  vcr_host_model i_host (.i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
  initial begin
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic give_verdict();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Write, then read back
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] r;
    logic a;
    i_host.write_reg({VCR_SLAVE_ADDR, 1'b0}, p, v, a);
    `CHK("ack", 1'b1, a)
    i_host.read_reg(p, r);
    `CHK("readback", v, r)
  endtask
  task automatic chk_init();
    logic [7:0] r;
    for (int p = 0; p < VCR_NUM_REGS; p++) begin
      i_host.read_reg(8'(p), r);
      `CHK("init", (p == 2) ? 8'h33 : 8'h00, r)
    end
  endtask
  initial begin
    logic [7:0] v;
    logic [7:0] r;
    logic a;
    int j;
    repeat (16) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clock);
    `CHK("rxg", -3, rxg)
    chk_init();
    for (int b = 0; b < 9; b++) begin
      v = (b == 8) ? 8'h60 : 8'h01 << b;
      wr(VCR_IDX_MODE_ONE, v);
      `CHK("alaw", v[7], law)
      `CHK("spk", v[6] & ~v[5], spk)
      `CHK("gpd", v[5], gpd)
      `CHK("txpd", v[4] | v[5], txpd)
      `CHK("rxpd", v[3] | v[5], rxpd)
      `CHK("slope", v[2:1], {sfe, sfs})
      `CHK("lin", v[0], lin)
    end
    wr(VCR_IDX_MODE_ONE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(VCR_IDX_MODE_TWO, {i[1:0], ~i[1:0], i[0], 1'b0, i[1], ~i[0]});
      `CHK("mic", (i == 3) ? 3'h0 : 3'h1 << i, inamp)
      `CHK("out", (i == 0) ? 3'h0 : 3'h1 << (3 - i), outamp)
      `CHK("frame", i[0], sfr)
      `CHK("sw", {~i[1], i[1]}, {to_a, to_c})
      `CHK("pad", ~i[0], pad)
    end
    wr(VCR_IDX_MODE_ONE, 8'h08);
    `CHK("rxdown", 3'h0, outamp)
    for (int i = 0; i < 8; i++) begin
      wr(VCR_IDX_GAIN, {i[0], i[2:0], ~i[0], ~i[2:0]});
      `CHK("txg", -6 + 2 * i, txg)
      `CHK("rxg", 9 - 3 * i, rxg)
      `CHK("mute", {i[0], ~i[0]}, {txo, rxo})
      `CHK("tlo", -22 + 2 * i, tlo)
      `CHK("thi", -20 + 2 * i, thi)
    end
    for (int i = 0; i < 8; i++) begin
      j = 2 * i + i % 2;
      wr(VCR_IDX_SIDETONE, {i[2:0], ~i[0], j[3:0]});
      `CHK("sten", i != 0, sten)
      if (i != 0) `CHK("stg", 2 * i - 17, stg)
      `CHK("tgon", ~i[0], tgon)
      `CHK("rten", j != 0, rten)
      if (j != 0) `CHK("rtg", 2 * j - 36, rtg)
    end
    for (int i = 0; i < 4; i++) begin
      wr(VCR_IDX_TONE, {1'b1, i[0], 2'h1, i[1:0], ~i[1:0]});
      `CHK("dual", 1'b1, dual)
      `CHK("send", i[0], send)
      `CHK("low", VCR_LOW_HZ[i], lhz)
      `CHK("high", VCR_HIGH_HZ[3 - i], hhz)
    end
    wr(VCR_IDX_TONE, 8'h09);
    `CHK("other", {1'b0, 5'h09}, {dual, oth})
    // Foreign address, unmapped pointer
    i_host.write_reg({VCR_SLAVE_ADDR ^ 7'h01, 1'b0}, VCR_IDX_GAIN, 8'h00, a);
    `CHK("nack", 1'b0, a)
    `CHK("txg", 8, txg)
    i_host.write_reg({VCR_SLAVE_ADDR, 1'b0}, 8'h05, 8'h5a, a);
    i_host.read_reg(8'h05, r);
    `CHK("unmapped", VCR_UNMAPPED_READ, r)
    // Software power-down keeps settings
    wr(VCR_IDX_GAIN, 8'h57);
    wr(VCR_IDX_MODE_ONE, 8'h20);
    i_host.read_reg(VCR_IDX_GAIN, r);
    `CHK("keep", 8'h57, r)
    wr(VCR_IDX_MODE_ONE, 8'h00);
    pin_n <= 1'b0;
    repeat (12) @(posedge i_clock);
    `CHK("pingpd", 1'b1, gpd)
    pin_n <= 1'b1;
    repeat (12) @(posedge i_clock);
    chk_init();
    give_verdict();
  end
  // Hang guard, about 1.6 times the run
  initial begin
    repeat (80000) @(posedge i_clock);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
